// file: hw/psi_status_defines.svh
// Register offsets, field masks, reset values and timing counts
// Assumes inclusion by bare name from any file of the status bank
`ifndef PSI_STATUS_DEFINES_SVH
`define PSI_STATUS_DEFINES_SVH

`define ADDR_NOP        6'h03
`define ADDR_SR1        6'h04
`define ADDR_SR2        6'h05
`define ADDR_SR3        6'h06
`define ADDR_UDB1_FIRST 6'h08
`define ADDR_UDB1_LAST  6'h0b
`define ADDR_UDB2_FIRST 6'h0c
`define ADDR_UDB2_LAST  6'h0f
`define ADDR_LAST       6'h1f

`define FRAME_BITS      8'h20
`define FRAME_WR_BIT    31
`define FRAME_ADDR_MSB  30
`define FRAME_ADDR_LSB  25
`define FRAME_DATA_MSB  24
`define FRAME_DATA_LSB  9

`define SR1_RC_MASK     16'hd4ff
`define SR1_DEEP_UV     16'h0100
`define SR1_XCT_ACTIVE  13
`define SR1_OTP_ERR     11
`define SR1_REG_OV      9
`define SR1_FRAME_FLT   12
`define SR2_RC_MASK     16'hf9f9
`define SR2_EN_CLR      8'h06
`define SR2_XCT_MASK    16'h1111
`define SR3_RC_MASK     16'h0223

`define RESP_RESET      32'h0000_0000
`define RST_FLAG_RESET  1'b1
`define SETTLE_CYC      2'h3

`define MCLK_MHZ        200
`define TRIG_TIMEOUT_US 100
`define TRIG_TIMEOUT_CYC (`TRIG_TIMEOUT_US * `MCLK_MHZ)
`define PIN_FILTER_NS   1000
`define PIN_FILTER_CYC  ((`PIN_FILTER_NS * `MCLK_MHZ) / 1000)

`endif

// file: hw/psi_status_pkg.sv
// Types shared by the status bank and its self-checking bench
// Assumes the defines header is compiled alongside
package psi_status_pkg;
  typedef logic [15:0] word_t;
  typedef logic [31:0] frame_t;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_DONE   = 4'b1000
  } frame_state_t;
endpackage

// file: hw/psi_transceiver_status_regs.sv
// Diagnostic status bank with its serial access port
// Assumes status sources on mclk; trigger pins and link are asynchronous
//
// What this block does
// R1 - No-operation write changes nothing; answer carries global status
// R2 - Status one flags latch on condition, clear on read, except live bits and bit 8
// R3 - Test done bit 15, aborted bit 14, bit 13 shows live test state
// R4 - Frame fault on parity error, bit count, read order, bad address
// R5 - Bit 11 mirrors trimming memory error live, never latched
// R6 - Regulator undervoltage latched at bit 10, overvoltage live at bit 9
// R7 - Deep undervoltage stops regulator, bit 8 clears only on enable low
// R8 - Trigger pin held over 100 us sets channel timeout flag
// R9 - Upstream buffer write while pending sets channel overwrite fault
// R10 - Missing, late or weak pulse sets channel slow flag
// R11 - Pulse below threshold beyond filter time sets undervoltage flag
// R12 - Status two holds latched line faults, channel two high byte
// R13 - Short to ground, overtemperature clear only on interface enable low
// R14 - During test mask battery short and undervoltage from summary bit
// R15 - Status three read-only; bit 15 shows self-test writability
// R16 - Queue lock sets on first read after full, clears on empty
// R17 - Trigger pin high past filter time sets level bit, read clears
// R18 - Upstream pending bits show live state, reads leave them
// R19 - Interface on bits report each channel active
// R20 - Bit 1 set after clock fault reset, cleared by read
// R21 - Bit 0 set after any reset, cleared by read
// R22 - Clearing registers return content then clear it
// R23 - Host reaches registers over the four-wire serial port
// R24 - Host clears channel enable to acknowledge sticky faults
// R25 - Reserved bits read zero; event in read cycle survives
// R26 - Live flags follow source every cycle, reads do not touch
`timescale 1ns/1ps
`include "psi_status_defines.svh"
module psi_transceiver_status_regs
  import psi_status_pkg::*;
#(
  parameter int TRIG_TIMEOUT_CYC = `TRIG_TIMEOUT_CYC,
  parameter int PIN_FILTER_CYC   = `PIN_FILTER_CYC
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  output logic             miso,
  output logic             miso_oe_n,
  input  wire logic        crosscouple_test_active,
  input  wire logic        xct_done_evt,
  input  wire logic        xct_abort_evt,
  input  wire logic        otp_error,
  input  wire logic        reg_undervoltage,
  input  wire logic        reg_overvoltage,
  input  wire logic        reg_deep_undervoltage,
  input  wire logic        read_order_error,
  input  wire logic [1:0]  trigger_pin,
  input  wire logic [1:0]  trigger_by_pin,
  input  wire logic [1:0]  pulse_slow_evt,
  input  wire logic [1:0]  pulse_uv_evt,
  input  wire logic [1:0]  xct_result_evt,
  input  wire logic [1:0]  buffer_empty_evt,
  input  wire logic [1:0]  open_load_evt,
  input  wire logic [1:0]  short_battery_evt,
  input  wire logic [1:0]  ground_leakage_evt,
  input  wire logic [1:0]  short_ground_evt,
  input  wire logic [1:0]  overtemp_evt,
  input  wire logic [1:0]  line_undervoltage,
  input  wire logic        regulator_enable,
  input  wire logic [1:0]  interface_enable,
  input  wire logic        selftest_write_allowed,
  input  wire logic        init_payload_ready,
  input  wire logic        regulator_running,
  input  wire logic        fifo_full,
  input  wire logic        fifo_empty,
  input  wire logic        fifo_read,
  input  wire logic [1:0]  upstream_pending,
  input  wire logic [1:0]  interface_active,
  input  wire logic        clock_fault_cause,
  output logic             regulator_shutdown,
  output logic             summary_fault_bit,
  output logic             fwd_valid,
  output logic             fwd_write,
  output logic      [5:0]  fwd_addr,
  output logic      [15:0] fwd_data
);
  frame_state_t state_reg;
  logic         cs_s;
  logic [7:0]   gray_s;
  logic [7:0]   gray_s_raw;
  logic [7:0]   count_bin;
  logic [7:0]   start_reg;
  logic [1:0]   settle_reg;
  frame_t       frame_word;
  frame_t       resp_reg;
  logic [7:0]   nbits;
  logic         frame_end;
  logic         f_wr;
  logic [5:0]   f_addr;
  word_t        f_data;
  logic         bad_len;
  logic         bad_par;
  logic         bad_addr;
  logic         frame_ok;
  logic         rd_sr1;
  logic         rd_sr2;
  logic         rd_sr3;
  logic [1:0]   udb_wr;
  logic [1:0]   trig_s;
  logic [14:0]  pin_cnt_reg [2];
  logic [1:0]   tout_evt;
  logic [1:0]   pin_evt;
  word_t        sr1_lat_reg;
  word_t        sr1_set;
  word_t        sr1_clr;
  word_t        sr1_val;
  word_t        sr2_lat_reg;
  word_t        sr2_set;
  word_t        sr2_clr;
  word_t        sr2_val;
  word_t        sr3_val;
  logic         lock_reg;
  logic         full_seen_reg;
  logic [1:0]   pin_lvl_reg;
  logic         clk_flag_reg;
  logic         rst_flag_reg;
  logic         first_reg;
  word_t        read_data;
  logic [7:0]   gsb;

  function automatic logic [7:0] gray2bin(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Link side on the serial clock [R23]
  spi_capture u_link (
    .sclk        (sclk),
    .cs_n        (cs_n),
    .mosi        (mosi),
    .resp_word   (resp_reg),
    .start_count (start_reg),
    .count_gray  (gray_s_raw),
    .frame_word  (frame_word),
    .miso        (miso)
  );

  sync3 #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
    .clk  (mclk),
    .rst  (srst),
    .din  (cs_n),
    .dout (cs_s)
  );

  sync3 #(.WIDTH(8), .INIT(8'h00)) u_cnt_sync (
    .clk  (mclk),
    .rst  (srst),
    .din  (gray_s_raw),
    .dout (gray_s)
  );

  sync3 #(.WIDTH(2), .INIT(2'b00)) u_pin_sync (
    .clk  (mclk),
    .rst  (srst),
    .din  (trigger_pin),
    .dout (trig_s)
  );

  assign miso_oe_n = cs_n;
  assign count_bin = gray2bin(gray_s);

  // Frame tracking: start snapshot, settle, then decode
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg  <= ST_IDLE;
      start_reg  <= 8'h00;
      settle_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          start_reg <= count_bin;
          if (!cs_s) begin
            state_reg <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          settle_reg <= 2'h0;
          if (cs_s) begin
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          settle_reg <= settle_reg + 2'h1;
          if (settle_reg == `SETTLE_CYC) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign frame_end = (state_reg == ST_DONE);
  assign nbits     = count_bin - start_reg;
  assign f_wr      = frame_word[`FRAME_WR_BIT];
  assign f_addr    = frame_word[`FRAME_ADDR_MSB:`FRAME_ADDR_LSB];
  assign f_data    = frame_word[`FRAME_DATA_MSB:`FRAME_DATA_LSB];
  assign bad_len   = (nbits != `FRAME_BITS);        // [R4]
  assign bad_par   = ~(^frame_word);                // [R4]
  assign bad_addr  = (f_addr > `ADDR_LAST);         // [R4]
  assign frame_ok  = frame_end & ~bad_len & ~bad_par & ~bad_addr;
  assign rd_sr1    = frame_ok & ~f_wr & (f_addr == `ADDR_SR1);
  assign rd_sr2    = frame_ok & ~f_wr & (f_addr == `ADDR_SR2);
  // Status three takes no writes; its sticky bits clear on read [R15]
  assign rd_sr3    = frame_ok & ~f_wr & (f_addr == `ADDR_SR3);
  assign udb_wr[0] = frame_ok & f_wr & (f_addr >= `ADDR_UDB1_FIRST)
                     & (f_addr <= `ADDR_UDB1_LAST);
  assign udb_wr[1] = frame_ok & f_wr & (f_addr >= `ADDR_UDB2_FIRST)
                     & (f_addr <= `ADDR_UDB2_LAST);

  // Frames for other registers go to the rest of the device
  always_ff @(posedge mclk) begin
    if (srst) begin
      fwd_valid <= 1'b0;
      fwd_write <= 1'b0;
      fwd_addr  <= 6'h00;
      fwd_data  <= 16'h0000;
    end else begin
      fwd_valid <= frame_ok & ((f_addr < `ADDR_NOP) | (f_addr > `ADDR_SR3));
      fwd_write <= f_wr;
      fwd_addr  <= f_addr;
      fwd_data  <= f_data;
    end
  end

  // Trigger pin high-time counters
  for (genvar c = 0; c < 2; c++) begin : g_pin
    always_ff @(posedge mclk) begin
      if (srst || !trig_s[c]) begin
        pin_cnt_reg[c] <= 15'h0000;
      end else if (pin_cnt_reg[c] != 15'(TRIG_TIMEOUT_CYC)) begin
        pin_cnt_reg[c] <= pin_cnt_reg[c] + 15'h0001;
      end
    end
    assign tout_evt[c] = trigger_by_pin[c] & trig_s[c]      // [R8]
                         & (pin_cnt_reg[c] == 15'(TRIG_TIMEOUT_CYC - 1));
    assign pin_evt[c]  = trig_s[c]
                         & (pin_cnt_reg[c] == 15'(PIN_FILTER_CYC - 1));
  end

  // Status one sets, clears and live view
  assign sr1_set = {xct_done_evt, xct_abort_evt, 1'b0,         // [R3]
                    read_order_error | (frame_end & ~frame_ok), // [R4]
                    1'b0, reg_undervoltage, 1'b0,               // [R6]
                    reg_deep_undervoltage,                      // [R7]
                    tout_evt[1], udb_wr[1] & upstream_pending[1], // [R8]
                    pulse_slow_evt[1], pulse_uv_evt[1],         // [R10] [R11]
                    tout_evt[0], udb_wr[0] & upstream_pending[0], // [R9]
                    pulse_slow_evt[0], pulse_uv_evt[0]};        // [R10] [R11]
  assign sr1_clr = (rd_sr1 ? `SR1_RC_MASK : 16'h0000)           // [R22]
                   | (regulator_enable ? 16'h0000 : `SR1_DEEP_UV); // [R7]

  // Set wins over clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      sr1_lat_reg <= 16'h0000;
    end else begin
      sr1_lat_reg <= sr1_set | (sr1_lat_reg & ~sr1_clr);     // [R2] [R25]
    end
  end

  always_comb begin
    sr1_val = sr1_lat_reg;
    sr1_val[`SR1_XCT_ACTIVE] = crosscouple_test_active;      // [R3] [R26]
    sr1_val[`SR1_OTP_ERR]    = otp_error;                    // [R5]
    sr1_val[`SR1_REG_OV]     = reg_overvoltage;              // [R6]
  end

  assign regulator_shutdown = sr1_lat_reg[8];                // [R7]

  // Status two per channel byte
  always_comb begin
    sr2_set = 16'h0000;
    sr2_clr = rd_sr2 ? `SR2_RC_MASK : 16'h0000;
    sr2_val = sr2_lat_reg;
    for (int c = 0; c < 2; c++) begin
      sr2_set[8*c +: 8] = {xct_result_evt[c], buffer_empty_evt[c],
                           open_load_evt[c], short_battery_evt[c],
                           ground_leakage_evt[c], short_ground_evt[c],
                           overtemp_evt[c],
                           line_undervoltage[c] & crosscouple_test_active};
      if (!interface_enable[c]) begin
        sr2_clr[8*c +: 8] = sr2_clr[8*c +: 8] | `SR2_EN_CLR; // [R13]
      end
      if (!crosscouple_test_active) begin
        sr2_val[8*c] = line_undervoltage[c];                 // [R14]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sr2_lat_reg <= 16'h0000;
    end else begin
      sr2_lat_reg <= sr2_set | (sr2_lat_reg & ~sr2_clr);     // [R12] [R25]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      summary_fault_bit <= 1'b0;
    end else begin
      summary_fault_bit <= |(sr2_val & ~(crosscouple_test_active
                             ? `SR2_XCT_MASK : 16'h0000));   // [R14]
    end
  end

  // Queue lock on first read after full
  always_ff @(posedge mclk) begin
    if (srst || fifo_empty) begin
      full_seen_reg <= 1'b0;
      lock_reg      <= 1'b0;                                 // [R16]
    end else begin
      full_seen_reg <= full_seen_reg | fifo_full;
      lock_reg      <= lock_reg | (fifo_read & full_seen_reg); // [R16]
    end
  end

  // Sticky bits of status three
  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_lvl_reg <= 2'b00;
    end else begin
      pin_lvl_reg <= pin_evt | (pin_lvl_reg & {2{~rd_sr3}}); // [R17]
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      first_reg    <= 1'b1;
      clk_flag_reg <= 1'b0;
      rst_flag_reg <= `RST_FLAG_RESET;                       // [R21]
    end else begin
      first_reg    <= 1'b0;
      clk_flag_reg <= (first_reg & clock_fault_cause)
                      | (clk_flag_reg & ~rd_sr3);            // [R20]
      rst_flag_reg <= rst_flag_reg & ~rd_sr3;                // [R21]
    end
  end

  assign sr3_val = {selftest_write_allowed, init_payload_ready, // [R15]
                    regulator_running, lock_reg, 2'b00,
                    pin_lvl_reg[1], upstream_pending[1],     // [R18]
                    interface_active[1], 1'b0,               // [R19]
                    pin_lvl_reg[0], upstream_pending[0],
                    interface_active[0], 1'b0,
                    clk_flag_reg, rst_flag_reg};

  // Read mux and answer word for the next frame
  always_comb begin
    case (f_addr)
      `ADDR_SR1: read_data = sr1_val;
      `ADDR_SR2: read_data = sr2_val;
      `ADDR_SR3: read_data = sr3_val;
      default:   read_data = 16'h0000;                       // [R25]
    endcase
  end

  assign gsb = {|sr1_val, |sr2_val, summary_fault_bit,
                sr1_lat_reg[`SR1_FRAME_FLT], rst_flag_reg, 3'b000};

  always_ff @(posedge mclk) begin
    if (srst) begin
      resp_reg <= `RESP_RESET;
    end else if (frame_end) begin
      resp_reg <= {gsb, (frame_ok & ~f_wr) ? read_data : 16'h0000,
                   8'h00};                                   // [R1] [R22]
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_good_read(logic [5:0] a);
    frame_ok && !f_wr && f_addr == a;
  endsequence

  chk_nop_answer: assert property (                        // [R1]
    frame_ok && f_wr && f_addr == `ADDR_NOP
    |=> resp_reg[31:24] == $past(gsb) && resp_reg[23:8] == 16'h0000)
    else $error("nop answer lacks global status");
  chk_sr1_clear: assert property (                         // [R2]
    s_good_read(`ADDR_SR1) ##0 (sr1_set == 16'h0000)
    |=> (sr1_lat_reg & `SR1_RC_MASK) == 16'h0000)
    else $error("status one not cleared by read");
  chk_test_live: assert property (                         // [R3]
    s_good_read(`ADDR_SR1)
    |=> resp_reg[21] == $past(crosscouple_test_active))
    else $error("test running bit not live");
  chk_frame_fault: assert property (                       // [R4]
    frame_end && (bad_len || bad_par) |=> sr1_lat_reg[12])
    else $error("bad frame did not raise fault");
  chk_otp_live: assert property (                          // [R5]
    s_good_read(`ADDR_SR1) |=> resp_reg[19] == $past(otp_error))
    else $error("trim error bit not live");
  chk_deep_uv_hold: assert property (                      // [R7]
    sr1_lat_reg[8] && regulator_enable |=> sr1_lat_reg[8])
    else $error("deep undervoltage cleared early");
  chk_pin_timeout: assert property (                       // [R8]
    tout_evt[0] |=> sr1_lat_reg[3] && pin_cnt_reg[0] == 15'(TRIG_TIMEOUT_CYC))
    else $error("trigger timeout not flagged");
  chk_overwrite: assert property (                         // [R9]
    udb_wr[1] && upstream_pending[1] |=> sr1_lat_reg[6])
    else $error("overwrite fault missed");
  chk_enable_clear: assert property (                      // [R13]
    !interface_enable[0] && !short_ground_evt[0] && !overtemp_evt[0]
    |=> sr2_lat_reg[2:1] == 2'b00)
    else $error("sticky line fault survived disable");
  chk_lock_clear: assert property (                        // [R16]
    fifo_empty |=> !lock_reg ##1 (lock_reg -> !$past(fifo_empty)))
    else $error("queue lock not cleared");
  chk_reset_flag: assert property (                        // [R21]
    @(posedge mclk) disable iff (1'b0) $fell(srst) |-> rst_flag_reg)
    else $error("reset flag missing after reset");
endmodule

// file: hw/spi_capture.sv
// Serial link front end on the serial clock: shift-in and bit count
// Assumes cs_n and mosi meet serial setup; resp_word stable in frame
`timescale 1ns/1ps
module spi_capture (
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic [31:0] resp_word,
  input  wire logic [7:0]  start_count,
  output logic      [7:0]  count_gray,
  output logic      [31:0] frame_word,
  output logic             miso
);
  logic [7:0] bin_reg = 8'h00;
  logic [7:0] bin_next;
  logic [7:0] bit_idx;

  assign bin_next = bin_reg + 8'h01;

  // Free-running count, sent across as gray code
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      bin_reg    <= bin_next;
      count_gray <= bin_next ^ (bin_next >> 1);
      frame_word <= {frame_word[30:0], mosi};
    end
  end

  // Response bit picked by position within the frame
  assign bit_idx = bin_reg - start_count;
  assign miso = (bit_idx < 8'h20) ? resp_word[5'h1f - bit_idx[4:0]]
                                  : 1'b0;
endmodule

// file: hw/sync3.sv
// Three-stage input synchroniser with agreement filter
// Assumes din is asynchronous to clk
`timescale 1ns/1ps
module sync3 #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      dout <= INIT;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule

// file: verification/spi_host.sv
// Serial host model sending whole frames to the status bank
// Assumes the bank answers MSB first, sampled on rising sclk
`timescale 1ns/1ps
module spi_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h0;
  end
  // Four-wire frame, clock still between frames
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    // Offset keeps link edges off the system clock edges
    #1.3;
    cs_n = 1'h0;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #80;
      rx[i] = miso;
      sclk = 1'h1;
      #80;
      sclk = 1'h0;
    end
    #80;
    cs_n = 1'h1;
    mosi = ~mosi;
    #200;
  endtask
endmodule

// file: verification/test_psi_transceiver_status_regs.sv
// Self-checking bench for the diagnostic status bank
// Assumes the serial host model and the design files are compiled first
`timescale 1ns/1ps
`include "psi_status_defines.svh"
module test_psi_transceiver_status_regs;
  import psi_status_pkg::*;
  logic       mclk = 1'h0, srst = 1'h1, sclk, cs_n, mosi, miso;
  logic       regulator_shutdown, crosscouple_test_active = 1'h0;
  logic       xct_done_evt = 1'h0, xct_abort_evt = 1'h0, otp_error = 1'h0;
  logic       reg_undervoltage = 1'h0, reg_overvoltage = 1'h0;
  logic       reg_deep_undervoltage = 1'h0, read_order_error = 1'h0;
  logic       regulator_enable = 1'h1, selftest_write_allowed = 1'h0;
  logic       init_payload_ready = 1'h0, regulator_running = 1'h0;
  logic       fifo_full = 1'h0, fifo_empty = 1'h1, fifo_read = 1'h0;
  logic       clock_fault_cause = 1'h1;
  logic [1:0] trigger_pin = '0, trigger_by_pin = '0, pulse_slow_evt = '0;
  logic [1:0] pulse_uv_evt = '0, xct_result_evt = '0, buffer_empty_evt = '0;
  logic [1:0] open_load_evt = '0, short_battery_evt = '0;
  logic [1:0] ground_leakage_evt = '0, short_ground_evt = '0;
  logic [1:0] overtemp_evt = '0, line_undervoltage = '0;
  logic [1:0] interface_enable = 2'h3, upstream_pending = '0;
  logic [1:0] interface_active = '0;
  logic       summary_fault_bit, fwd_valid, fwd_write;
  logic [5:0] fwd_addr;
  word_t      fwd_data;
  int         n_fwd = 0;
  int         n_fail = 0, samples_checked = 0;
  frame_t     r;

  always #2.5 mclk = ~mclk;
  // Counts forwarded frames
  always @(negedge mclk) if (fwd_valid === 1'h1) n_fwd++;

  spi_host host (.sclk, .cs_n, .mosi, .miso);

  psi_transceiver_status_regs #(.TRIG_TIMEOUT_CYC(50), .PIN_FILTER_CYC(8))
    uut (.mclk, .srst, .sclk, .cs_n, .mosi, .miso, .miso_oe_n(),
      .crosscouple_test_active, .xct_done_evt, .xct_abort_evt, .otp_error,
      .reg_undervoltage, .reg_overvoltage, .reg_deep_undervoltage,
      .read_order_error, .trigger_pin, .trigger_by_pin, .pulse_slow_evt,
      .pulse_uv_evt, .xct_result_evt, .buffer_empty_evt, .open_load_evt,
      .short_battery_evt, .ground_leakage_evt, .short_ground_evt,
      .overtemp_evt, .line_undervoltage, .regulator_enable,
      .interface_enable, .selftest_write_allowed, .init_payload_ready,
      .regulator_running, .fifo_full, .fifo_empty, .fifo_read,
      .upstream_pending, .interface_active, .clock_fault_cause,
      .regulator_shutdown, .summary_fault_bit, .fwd_valid,
      .fwd_write, .fwd_addr, .fwd_data);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic chk(string s, word_t e, word_t g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask

  function automatic frame_t mk(logic w, logic [5:0] a, word_t d);
    frame_t f;
    f = {w, a, d, 8'h00, 1'h0};
    f[0] = ~^f[31:1];
    return f;
  endfunction

  // Read one register, then a no-operation write to fetch the answer
  task automatic rc(logic [5:0] a, word_t e);
    host.xfer(mk(1'h0, a, 16'h0000), r);
    host.xfer(mk(1'h1, `ADDR_NOP, 16'h0000), r);
    samples_checked++;
    if (r[23:8] !== e) begin
      n_fail++;
      $display("unexpected reg %h exp %h got %h", a, e, r[23:8]);
    end
  endtask

  task automatic t_reset();
    rc(`ADDR_SR3, 16'h0003);
    chk("global_status", 16'h0008, 16'(r[31:24]));
    rc(`ADDR_SR3, 16'h0000);
  endtask

  task automatic t_live();
    crosscouple_test_active <= 1'h1;
    otp_error <= 1'h1;
    reg_overvoltage <= 1'h1;
    reg_undervoltage <= 1'h1;
    cyc(1);
    reg_undervoltage <= 1'h0;
    cyc(4);
    rc(`ADDR_SR1, 16'h2e00);
    rc(`ADDR_SR1, 16'h2a00);
    crosscouple_test_active <= 1'h0;
    otp_error <= 1'h0;
    reg_overvoltage <= 1'h0;
    cyc(4);
    rc(`ADDR_SR1, 16'h0000);
  endtask

  task automatic t_events();
    xct_done_evt <= 1'h1;
    xct_abort_evt <= 1'h1;
    read_order_error <= 1'h1;
    pulse_slow_evt <= 2'h3;
    pulse_uv_evt <= 2'h3;
    cyc(1);
    {xct_done_evt, xct_abort_evt, read_order_error} <= 3'h0;
    pulse_slow_evt <= 2'h0;
    pulse_uv_evt <= 2'h0;
    rc(`ADDR_SR1, 16'hd033);
    host.xfer(mk(1'h0, `ADDR_SR1, 16'h0000) ^ 32'h1, r);
    rc(`ADDR_SR1, 16'h1000);
    rc(`ADDR_SR1, 16'h0000);
    host.xfer(mk(1'h0, 6'h2a, 16'h0000), r);
    rc(`ADDR_SR1, 16'h1000);
    rc(`ADDR_SR1, 16'h0000);
  endtask

  task automatic t_deep();
    reg_deep_undervoltage <= 1'h1;
    cyc(1);
    reg_deep_undervoltage <= 1'h0;
    cyc(4);
    samples_checked++;
    if (regulator_shutdown !== 1'h1) begin
      n_fail++;
      $display("unexpected regulator_shutdown exp 1 got %b",
               regulator_shutdown);
    end
    rc(`ADDR_SR1, 16'h0100);
    rc(`ADDR_SR1, 16'h0100);
    regulator_enable <= 1'h0;
    cyc(3);
    regulator_enable <= 1'h1;
    cyc(3);
    rc(`ADDR_SR1, 16'h0000);
  endtask

  task automatic t_line();
    {xct_result_evt, buffer_empty_evt, open_load_evt} <= 6'h3f;
    {short_battery_evt, ground_leakage_evt} <= 4'hf;
    {short_ground_evt, overtemp_evt} <= 4'hf;
    line_undervoltage <= 2'h1;
    cyc(1);
    {xct_result_evt, buffer_empty_evt, open_load_evt} <= 6'h00;
    {short_battery_evt, ground_leakage_evt} <= 4'h0;
    {short_ground_evt, overtemp_evt} <= 4'h0;
    rc(`ADDR_SR2, 16'hfeff);
    rc(`ADDR_SR2, 16'h0607);
    chk("summary_fault_bit", 16'h0001, 16'(summary_fault_bit));
    line_undervoltage <= 2'h0;
    interface_enable <= 2'h0;
    cyc(3);
    interface_enable <= 2'h3;
    rc(`ADDR_SR2, 16'h0000);
    crosscouple_test_active <= 1'h1;
    line_undervoltage <= 2'h1;
    cyc(3);
    chk("summary_fault_bit", 16'h0000, 16'(summary_fault_bit));
    line_undervoltage <= 2'h0;
    rc(`ADDR_SR2, 16'h0001);
    crosscouple_test_active <= 1'h0;
  endtask

  task automatic t_sr3();
    {selftest_write_allowed, init_payload_ready, regulator_running} <= 3'h7;
    upstream_pending <= 2'h3;
    interface_active <= 2'h3;
    fifo_empty <= 1'h0;
    fifo_full <= 1'h1;
    cyc(1);
    fifo_full <= 1'h0;
    fifo_read <= 1'h1;
    cyc(1);
    fifo_read <= 1'h0;
    host.xfer(mk(1'h1, `ADDR_UDB1_FIRST, 16'h1234), r);
    host.xfer(mk(1'h1, `ADDR_UDB2_FIRST, 16'h5678), r);
    chk("fwd_count", 16'h0002, 16'(n_fwd));
    chk("fwd_addr", 16'(`ADDR_UDB2_FIRST), 16'(fwd_addr));
    chk("fwd_data", 16'h5678, fwd_data);
    chk("fwd_write", 16'h0001, 16'(fwd_write));
    rc(`ADDR_SR1, 16'h0044);
    rc(`ADDR_SR3, 16'hf198);
    rc(`ADDR_SR3, 16'hf198);
    {selftest_write_allowed, init_payload_ready, regulator_running} <= 3'h0;
    upstream_pending <= 2'h0;
    interface_active <= 2'h0;
    fifo_empty <= 1'h1;
    cyc(4);
    rc(`ADDR_SR3, 16'h0000);
  endtask

  task automatic t_trig();
    trigger_by_pin <= 2'h3;
    trigger_pin <= 2'h3;
    cyc(80);
    trigger_pin <= 2'h0;
    trigger_by_pin <= 2'h0;
    cyc(6);
    rc(`ADDR_SR1, 16'h0088);
    rc(`ADDR_SR3, 16'h0220);
    rc(`ADDR_SR3, 16'h0000);
  endtask

  initial begin
    cyc(2);
    srst <= 1'h0;
    cyc(3);
    clock_fault_cause <= 1'h0;
    cyc(5);
    t_reset();
    t_live();
    t_events();
    t_deep();
    t_line();
    t_sr3();
    t_trig();
    report_and_stop();
  end

  initial begin
    #400000;
    n_fail++;
    report_and_stop();
  end
endmodule
